// >>> verilog/spfc_ctrl.v
`timescale 1ns/100ps
`include "spfc_defs.vh"
// Summary of operation
// RQ1: Request ready interrupt while enable, global enable set and store-enable clear.
// RQ2: No ready interrupt during EEPROM write or flash store operation.
// RQ3: Section-busy bit reads zero always.
// RQ4: Signature command plus load within three cycles returns signature byte.
// RQ5: Store within four cycles after signature command does nothing.
// RQ6: Section-read-enable command clears the temporary page buffer.
// RQ7: Lock-read command plus load returns lock or fuse by pointer bit 0.
// RQ8: Page-program command plus store programs page from buffer, page from pointer.
// RQ9: Page-program bit clears on completion or four-cycle timeout.
// RQ10: Page-erase command plus store erases page from pointer upper bits.
// RQ11: Page-erase bit clears on completion or four-cycle timeout.
// RQ12: Core halted for the whole erase or program.
// RQ13: Store-enable opens four-cycle window; clears on completion or expiry.
// RQ14: Plain store-enable stores data pair into buffer word at pointer.
// RQ15: Store-enable stays high until erase or program finishes.
// RQ16: Only listed low five-bit codes act; others ignored.
// RQ17: Flash writes timed 3.7 ms to 4.5 ms from the oscillator.
// RQ18: A write in progress completes despite reset.
// RQ19: Software polls store-enable and EEPROM busy before new command.
// RQ20: Software checks section-busy and re-enables section after programming.
// RQ21: EEPROM write blocks self-programming commands and fuse/lock reads.
// RQ22: Buffer erased after page program and after reset.
// RQ23: EEPROM write during buffer loading loses loaded data.
// RQ24: Programmed fuse/lock bits read zero, unprogrammed read one.
// RQ25: Arming window is a down-counter, cleared when instruction accepted.
// RQ26: Control writes ignored while erase or program runs.
module spfc_ctrl #(
    parameter [17:0] OP_CYCLES = 18'd92500
) (
    input wire ref_clk,
    input wire resetn,
    input wire por_n,
    input wire [5:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    input wire global_irq_en,
    input wire eeprom_write_busy,
    input wire store_instr,
    input wire load_instr,
    input wire [15:0] ptr,
    input wire [15:0] data_pair,
    input wire [7:0] lock_bits,
    input wire [7:0] fuse_low,
    input wire [7:0] sig_byte,
    output reg [7:0] io_rdata,
    output reg ready_irq,
    output reg core_halt,
    output reg load_valid,
    output reg [7:0] load_data,
    output reg flash_erase,
    output reg flash_program,
    output reg [7:0] flash_page,
    output reg [511:0] page_buffer_out
);
    localparam CYC_MIN = (`SPFC_T_WRITE_MIN_NS + `SPFC_REF_PERIOD_NS - 1) / `SPFC_REF_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and input synchronisers
    reg [1:0] rst_sync_ff;
    reg [1:0] ee_sync_ff;
    wire rst_n;
    wire ee_busy;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ee_sync_ff <= 2'b00;
        end else begin
            ee_sync_ff <= {ee_sync_ff[0], eeprom_write_busy};
        end
    end
    assign ee_busy = ee_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // Control register state
    reg irq_en_ff;
    reg [4:0] cmd_ff;
    reg sig_sel_ff;
    reg op_erase_ff;
    reg op_prog_ff;
    reg [7:0] flash_page_ff;
    wire op_busy;
    wire op_done;
    wire csr_hit;
    wire csr_wr;
    wire [4:0] wcmd;
    wire cmd_valid;
    wire win_active;
    wire win_expire;
    wire st_take;
    wire ld_take;
    wire [2:0] win_len;
    wire op_start;
    wire ld_age_ok;

    // Decode of a legal command code
    function is_valid_cmd;
        input [4:0] c;
        begin
            is_valid_cmd = (c == `SPFC_CMD_SIG) || (c == `SPFC_CMD_LOCK) || (c == `SPFC_CMD_PROG) ||
                (c == `SPFC_CMD_ERASE) || (c == `SPFC_CMD_LOAD);
        end
    endfunction

    assign csr_hit = (io_addr == `SPFC_CSR_ADDR);
    // Writes ignored while a flash write runs or an erase or program bit is still set
    assign csr_wr = csr_hit && io_wr && !op_busy && !op_erase_ff && !op_prog_ff; // RQ26
    assign wcmd = io_wdata[4:0];
    assign cmd_valid = is_valid_cmd(wcmd) && !ee_busy; // RQ16 RQ21
    // Every command arms the store window; the shorter load window is tracked apart
    assign win_len = (wcmd[3] || wcmd[4]) ? `SPFC_STORE_WIN : `SPFC_STORE_WIN; // RQ13
    assign st_take = store_instr && win_active && cmd_ff[0] && !ee_busy;
    // Lock, fuse and signature reads are refused during an EEPROM write
    assign ld_take = load_instr && win_active && (cmd_ff[3] || sig_sel_ff) && ld_age_ok && !ee_busy; // RQ21

    // Load window tracked separately: three cycles
    reg [2:0] age_ff;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            age_ff <= 3'h0;
        end else if (csr_wr && cmd_valid) begin
            age_ff <= `SPFC_LOAD_WIN;
        end else if (age_ff != 3'h0) begin
            age_ff <= age_ff - 3'h1;
        end
    end
    assign ld_age_ok = (age_ff != 3'h0); // RQ4 RQ7

    spfc_arm_timer u_arm (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load(csr_wr && cmd_valid),
        .load_val(win_len),
        .consume(st_take || ld_take),
        .active(win_active),
        .expire(win_expire)
    ); // RQ25

    // Erase or program start on accepted store
    assign op_start = st_take && (cmd_ff == `SPFC_CMD_ERASE || cmd_ff == `SPFC_CMD_PROG); // RQ8 RQ10

    spfc_op_timer #(
        .OP_CYCLES(OP_CYCLES)
    ) u_op (
        .ref_clk(ref_clk),
        .por_n(por_n),
        .start(op_start),
        .busy(op_busy),
        .done(op_done)
    ); // RQ17 RQ18

    // Command bits: arm, auto-clear on completion or timeout
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_ff <= 1'b0;
            cmd_ff <= 5'h00;
            sig_sel_ff <= 1'b0;
        end else begin
            if (csr_wr) begin
                irq_en_ff <= io_wdata[`SPFC_BIT_IRQ_EN];
            end
            if (csr_wr && cmd_valid) begin
                cmd_ff <= wcmd; // RQ16
                // Signature select only rides on a plain store-enable code
                sig_sel_ff <= io_wdata[`SPFC_BIT_SIG_READ] && (wcmd == `SPFC_CMD_LOAD); // RQ4
            end else if (op_done) begin
                cmd_ff <= 5'h00; // RQ15
                sig_sel_ff <= 1'b0;
            end else if ((st_take || ld_take || win_expire) && !op_start) begin
                // A started erase or program keeps its bits up until done
                cmd_ff <= 5'h00; // RQ9 RQ11 RQ13
                sig_sel_ff <= 1'b0;
            end
        end
    end

    // Running operation survives a core reset so that the write completes
    always @(posedge ref_clk or negedge por_n) begin
        if (!por_n) begin
            op_erase_ff <= 1'b0;
            op_prog_ff <= 1'b0;
        end else if (op_start) begin
            op_erase_ff <= (cmd_ff == `SPFC_CMD_ERASE);
            op_prog_ff <= (cmd_ff == `SPFC_CMD_PROG);
        end else if (op_done) begin
            op_erase_ff <= 1'b0;
            op_prog_ff <= 1'b0;
        end
    end // RQ18

    ////////////////////////////////////////////////////////////////////////
    // Temporary page buffer, word indexed by pointer bits 5:1
    reg [15:0] buf_ff [0:`SPFC_WORDS-1];
    wire buf_clear;
    wire buf_store;
    wire [`SPFC_WORD_BITS-1:0] widx;
    genvar gi;

    assign widx = ptr[`SPFC_WORD_BITS:1]; // RQ14
    // A store after the signature command leaves the buffer alone
    assign buf_store = st_take && (cmd_ff == `SPFC_CMD_LOAD) && !sig_sel_ff; // RQ5 RQ14
    assign buf_clear = (csr_wr && cmd_valid && wcmd == `SPFC_CMD_SECTRE && io_wdata[`SPFC_BIT_SECT_RE]) // RQ6
        || (op_done && op_prog_ff) // RQ22
        || ee_busy; // RQ23

    generate
        for (gi = 0; gi < `SPFC_WORDS; gi = gi + 1) begin : g_buf
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    buf_ff[gi] <= 16'hffff; // RQ22
                end else if (buf_clear) begin
                    buf_ff[gi] <= 16'hffff;
                end else if (buf_store && widx == gi) begin
                    buf_ff[gi] <= data_pair; // RQ14
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Outputs to flash, core and register read
    integer k;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_buffer_out <= 512'h0;
        end else begin
            for (k = 0; k < `SPFC_WORDS; k = k + 1) begin
                page_buffer_out[k*16 +: 16] <= buf_ff[k];
            end
        end
    end

    // Halt and flash strobes line up with the timer and outlive a core reset
    always @(posedge ref_clk or negedge por_n) begin
        if (!por_n) begin
            flash_page_ff <= 8'h00;
            core_halt <= 1'b0;
            flash_erase <= 1'b0;
            flash_program <= 1'b0;
            flash_page <= 8'h00;
        end else begin
            if (op_start) begin
                flash_page_ff <= ptr[`SPFC_PAGE_BITS+5:6]; // RQ8 RQ10
            end
            core_halt <= op_start || (op_busy && !op_done); // RQ12
            if (op_start) begin
                flash_erase <= (cmd_ff == `SPFC_CMD_ERASE); // RQ10
                flash_program <= (cmd_ff == `SPFC_CMD_PROG); // RQ8
            end else begin
                flash_erase <= op_erase_ff && op_busy && !op_done; // RQ10
                flash_program <= op_prog_ff && op_busy && !op_done; // RQ8
            end
            flash_page <= flash_page_ff;
        end
    end // RQ18

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            io_rdata <= `SPFC_CSR_RESET;
            ready_irq <= 1'b0;
            load_valid <= 1'b0;
            load_data <= 8'h00;
        end else begin
            io_rdata <= (csr_hit && io_rd) ? {irq_en_ff, 1'b0, sig_sel_ff, cmd_ff[4:1],
                cmd_ff[0] | op_erase_ff | op_prog_ff} : 8'h00; // RQ3 RQ15
            ready_irq <= irq_en_ff && global_irq_en && !cmd_ff[0] && !op_busy && !ee_busy; // RQ1 RQ2
            load_valid <= ld_take;
            if (ld_take) begin
                // Fuse/lock read as stored: programmed bit is zero
                load_data <= sig_sel_ff ? sig_byte : (ptr[0] ? lock_bits : fuse_low); // RQ4 RQ7 RQ24
            end
        end
    end
endmodule // spfc_ctrl

// >>> verilog/spfc_defs.vh
`ifndef SPFC_DEFS_VH
`define SPFC_DEFS_VH

// Register address of program_store_control
`define SPFC_CSR_ADDR 6'h37
// Field positions
`define SPFC_BIT_STORE_EN 0
`define SPFC_BIT_PAGE_ERASE 1
`define SPFC_BIT_PAGE_PROG 2
`define SPFC_BIT_LOCK_READ 3
`define SPFC_BIT_SECT_RE 4
`define SPFC_BIT_SIG_READ 5
`define SPFC_BIT_SECT_BUSY 6
`define SPFC_BIT_IRQ_EN 7
// Reset value
`define SPFC_CSR_RESET 8'h00
// Valid command codes in the low five bits
`define SPFC_CMD_SIG 5'h11
`define SPFC_CMD_SECT 5'h11
`define SPFC_CMD_LOCK 5'h09
`define SPFC_CMD_PROG 5'h05
`define SPFC_CMD_ERASE 5'h03
`define SPFC_CMD_LOAD 5'h01
`define SPFC_CMD_SECTRE 5'h11
// Arming windows in cycles
`define SPFC_STORE_WIN 3'd4
`define SPFC_LOAD_WIN 3'd3
// Flash write time in ns and oscillator
`define SPFC_T_WRITE_MIN_NS 3700000
`define SPFC_T_WRITE_MAX_NS 4500000
`define SPFC_REF_PERIOD_NS 40
// Page buffer geometry
`define SPFC_WORD_BITS 5
`define SPFC_WORDS 32
`define SPFC_PAGE_BITS 8

`endif

// >>> verilog/spfc_arm_timer.v
`timescale 1ns/100ps
// Down-counter for the short arming window after a control write
module spfc_arm_timer (
    input wire ref_clk,
    input wire rst_n,
    input wire load,
    input wire [2:0] load_val,
    input wire consume,
    output wire active,
    output wire expire
);
    reg [2:0] cnt_ff;
    reg [2:0] nxt_cnt;

    // Reload on write, clear on accept, else count down
    always @* begin
        nxt_cnt = cnt_ff;
        if (load) begin
            nxt_cnt = load_val;
        end else if (consume) begin
            nxt_cnt = 3'h0;
        end else if (cnt_ff != 3'h0) begin
            nxt_cnt = cnt_ff - 3'h1;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 3'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign active = (cnt_ff != 3'h0);
    assign expire = (cnt_ff == 3'h1) && !load && !consume;
endmodule // spfc_arm_timer

// >>> verilog/spfc_op_timer.v
`timescale 1ns/100ps
// Times one flash write from the oscillator tick; not stopped by reset of the core
module spfc_op_timer #(
    parameter [17:0] OP_CYCLES = 18'd92500
) (
    input wire ref_clk,
    input wire por_n,
    input wire start,
    output wire busy,
    output wire done
);
    reg [17:0] cnt_ff;

    // Load on start, count down to zero
    always @(posedge ref_clk or negedge por_n) begin
        if (!por_n) begin
            cnt_ff <= 18'h0;
        end else if (start) begin
            cnt_ff <= OP_CYCLES;
        end else if (cnt_ff != 18'h0) begin
            cnt_ff <= cnt_ff - 18'h1;
        end
    end

    assign busy = (cnt_ff != 18'h0);
    assign done = (cnt_ff == 18'h1);
endmodule // spfc_op_timer

// >>> bench/spfc_asserts.sv
`timescale 1ns/100ps
// Port checker for the flash self-programming control
module spfc_asserts #(
    parameter [17:0] OP_CYCLES = 18'd92500
) (
    input wire ref_clk,
    input wire resetn,
    input wire [5:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    input wire eeprom_write_busy,
    input wire store_instr,
    input wire load_instr,
    input wire [7:0] io_rdata,
    input wire ready_irq,
    input wire core_halt,
    input wire load_valid,
    input wire flash_erase,
    input wire flash_program
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Counts cycles of one halt; a core reset does not stop the operation
    reg [17:0] halt_cnt_ff = 18'h0;
    always @(posedge ref_clk) begin
        halt_cnt_ff <= core_halt ? halt_cnt_ff + 18'h1 : 18'h0;
    end
    // Control write that the block must take
    wire csr_wr = io_wr && io_addr == 6'h37 && !core_halt && !eeprom_write_busy;
    sequence s_arm(cmd);
        csr_wr && io_wdata == cmd;
    endsequence
    ////////////////////////////////////////
    property p_busy_zero;
        io_rd && io_addr == 6'h37 |=> !io_rdata[6];
    endproperty
    a_busy_zero: assert property (p_busy_zero) else $error("busy bit set");
    property p_erase_go;
        s_arm(8'h03) ##[1:3] store_instr |-> ##[1:2] flash_erase && core_halt;
    endproperty
    a_erase_go: assert property (p_erase_go) else $error("erase not started");
    property p_prog_go;
        s_arm(8'h05) ##[1:3] store_instr |-> ##[1:2] flash_program && core_halt;
    endproperty
    a_prog_go: assert property (p_prog_go) else $error("program not started");
    property p_erase_lapse;
        s_arm(8'h03) ##1 !store_instr [*4] ##[1:4] store_instr |=> !flash_erase;
    endproperty
    a_erase_lapse: assert property (p_erase_lapse) else $error("late erase ran");
    property p_halt_op;
        core_halt == (flash_erase || flash_program);
    endproperty
    a_halt_op: assert property (p_halt_op) else $error("halt not matching op");
    property p_en_hold;
        io_rd && io_addr == 6'h37 && core_halt ##1 core_halt |-> io_rdata[0];
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable dropped in op");
    property p_irq_op;
        flash_erase || flash_program |-> !ready_irq;
    endproperty
    a_irq_op: assert property (p_irq_op) else $error("irq while busy");
    property p_irq_ee;
        eeprom_write_busy [*4] |-> !ready_irq;
    endproperty
    a_irq_ee: assert property (p_irq_ee) else $error("irq during eeprom write");
    property p_load_ans;
        load_valid |-> $past(load_instr) && !$past(load_valid);
    endproperty
    a_load_ans: assert property (p_load_ans) else $error("stray load answer");
    property p_op_len;
        $fell(core_halt) |-> halt_cnt_ff >= OP_CYCLES - 18'h1 && halt_cnt_ff <= OP_CYCLES + 18'h1;
    endproperty
    a_op_len: assert property (p_op_len) else $error("op length wrong");
endmodule // spfc_asserts

bind spfc_ctrl spfc_asserts #(.OP_CYCLES(OP_CYCLES)) u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .eeprom_write_busy(eeprom_write_busy), .store_instr(store_instr),
    .load_instr(load_instr), .io_rdata(io_rdata), .ready_irq(ready_irq), .core_halt(core_halt),
    .load_valid(load_valid), .flash_erase(flash_erase), .flash_program(flash_program)
);

// >>> bench/spfc_core_model.sv
`timescale 1ns/100ps
// Core side: issues store and load instructions, keeps loaded byte
module spfc_core_model (
    input wire ref_clk,
    input wire core_halt,
    input wire req_st,
    input wire req_ld,
    input wire load_valid,
    input wire [7:0] load_data,
    output wire store_instr,
    output wire load_instr,
    output reg [7:0] got = 8'h00
);
    // A halted core issues nothing
    assign store_instr = req_st & ~core_halt;
    assign load_instr = req_ld & ~core_halt;
    // Destination register of a load
    always @(posedge ref_clk) begin
        if (load_valid) begin
            got <= load_data;
        end
    end
endmodule // spfc_core_model

// >>> bench/testbench.sv
`timescale 1ns/100ps
// Self-checking bench for the flash self-programming control
module testbench;
    reg ref_clk = 1'b0;
    reg resetn = 1'b0;
    reg por_n = 1'b0;
    reg [5:0] io_addr = 6'h0;
    reg io_wr = 1'b0;
    reg io_rd = 1'b0;
    reg [7:0] io_wdata = 8'h0;
    reg gie = 1'b0;
    reg ee_busy = 1'b0;
    reg req_st = 1'b0;
    reg req_ld = 1'b0;
    reg [15:0] ptr = 16'h0;
    reg [15:0] dpair = 16'h0;
    reg [7:0] v;
    wire st_i, ld_i, irq, halt, lvalid, fer, fpr;
    wire [7:0] rdata, ldata, page, got;
    wire [511:0] buf_out;
    integer error_cnt = 0;
    integer checks_done = 0;
    localparam [511:0] BLANK = {32{16'hffff}};
    always #20 ref_clk = ~ref_clk;
    spfc_ctrl #(.OP_CYCLES(18'd20)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .por_n(por_n), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .global_irq_en(gie), .eeprom_write_busy(ee_busy),
        .store_instr(st_i), .load_instr(ld_i), .ptr(ptr), .data_pair(dpair), .lock_bits(8'h3c),
        .fuse_low(8'h62), .sig_byte(8'h95), .io_rdata(rdata), .ready_irq(irq), .core_halt(halt),
        .load_valid(lvalid), .load_data(ldata), .flash_erase(fer), .flash_program(fpr),
        .flash_page(page), .page_buffer_out(buf_out)
    );
    spfc_core_model u_core (
        .ref_clk(ref_clk), .core_halt(halt), .req_st(req_st), .req_ld(req_ld),
        .load_valid(lvalid), .load_data(ldata), .store_instr(st_i), .load_instr(ld_i), .got(got)
    );
    ////////////////////////////////////////
    task chk(input [511:0] g, input [511:0] e);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("mismatch at %0t: got %0h exp %0h", $time, g, e);
            end
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", checks_done, error_cnt);
            if (error_cnt == 0 && checks_done > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    task wr(input [7:0] d);
        begin
            @(posedge ref_clk);
            io_addr <= 6'h37;
            io_wdata <= d;
            io_wr <= 1'b1;
            @(posedge ref_clk);
            io_wr <= 1'b0;
        end
    endtask
    task rd(input [5:0] a);
        begin
            @(posedge ref_clk);
            io_addr <= a;
            io_rd <= 1'b1;
            @(posedge ref_clk);
            io_rd <= 1'b0;
            #1;
            v = rdata;
        end
    endtask
    task st(input [15:0] p, input [15:0] d);
        begin
            @(posedge ref_clk);
            ptr <= p;
            dpair <= d;
            req_st <= 1'b1;
            @(posedge ref_clk);
            req_st <= 1'b0;
        end
    endtask
    task ld(input [15:0] p);
        begin
            @(posedge ref_clk);
            ptr <= p;
            req_ld <= 1'b1;
            @(posedge ref_clk);
            req_ld <= 1'b0;
            repeat (2) @(posedge ref_clk);
            #1;
        end
    endtask
    task wait_idle;
        integer n;
        begin
            n = 0;
            while (halt === 1'b1 && n < 200) begin
                @(posedge ref_clk);
                n = n + 1;
            end
            if (n == 200) begin
                error_cnt = error_cnt + 1;
                $display("mismatch at %0t: halt stuck", $time);
                final_report;
            end
        end
    endtask
    ////////////////////////////////////////
    task t_fill;
        begin
            rd(6'h30);
            chk(v, 8'h00);
            rd(6'h37);
            chk(v, 8'h00);
            chk(buf_out, BLANK);
            wr(8'h01);
            st(16'h0007, 16'h1234);
            rd(6'h37);
            chk(v, 8'h00);
            chk(buf_out[63:48], 16'h1234);
            wr(8'h11);
            repeat (2) @(posedge ref_clk);
            chk(buf_out, BLANK);
            $display("test fill done");
        end
    endtask
    task t_ops;
        integer i;
        reg [7:0] cmd;
        begin
            wr(8'h01);
            st(16'h0040, 16'habcd);
            for (i = 0; i < 2; i = i + 1) begin
                cmd = i ? 8'h05 : 8'h03;
                wr(cmd);
                st(16'h1a40, 16'h5555);
                @(posedge ref_clk);
                #1;
                chk({halt, fer, fpr}, {1'b1, ~cmd[2], cmd[2]});
                chk(page, 8'h69);
                rd(6'h37);
                chk(v[0], 1'b1);
                wait_idle;
                rd(6'h37);
                chk(v, 8'h00);
            end
            chk(buf_out, BLANK);
            wr(8'h11);
            $display("test ops done");
        end
    endtask
    task t_reset;
        begin
            wr(8'h03);
            st(16'h0080, 16'h0);
            resetn <= 1'b0;
            repeat (2) @(posedge ref_clk);
            resetn <= 1'b1;
            repeat (3) @(posedge ref_clk);
            #1;
            chk({halt, fer}, 2'b11);
            wait_idle;
            rd(6'h37);
            chk(v, 8'h00);
            $display("test reset done");
        end
    endtask
    task t_refuse;
        begin
            wr(8'h03);
            repeat (6) @(posedge ref_clk);
            st(16'h0000, 16'h1111);
            rd(6'h37);
            chk({halt, fer, v}, 10'h000);
            wr(8'h07);
            st(16'h0000, 16'h1111);
            wr(8'h21);
            st(16'h0000, 16'h1111);
            rd(6'h37);
            chk({halt, fpr, fer}, 3'b000);
            chk(buf_out, BLANK);
            $display("test refuse done");
        end
    endtask
    task t_reads;
        begin
            wr(8'h09);
            ld(16'h0001);
            chk(got, 8'h3c);
            wr(8'h09);
            ld(16'h0000);
            chk(got, 8'h62);
            wr(8'h21);
            ld(16'h0000);
            chk(got, 8'h95);
            $display("test reads done");
        end
    endtask
    task t_irq_ee;
        begin
            wr(8'h01);
            st(16'h0000, 16'h2222);
            gie <= 1'b1;
            wr(8'h81);
            @(posedge ref_clk);
            #1;
            chk(irq, 1'b0);
            repeat (6) @(posedge ref_clk);
            chk(irq, 1'b1);
            ee_busy <= 1'b1;
            repeat (4) @(posedge ref_clk);
            #1;
            chk({irq, buf_out}, {1'b0, BLANK});
            wr(8'h03);
            st(16'h0000, 16'h0);
            @(posedge ref_clk);
            #1;
            chk(halt, 1'b0);
            ee_busy <= 1'b0;
            gie <= 1'b0;
            $display("test irq done");
        end
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_fill;
        t_ops;
        t_reset;
        t_refuse;
        t_reads;
        t_irq_ee;
        final_report;
    end
endmodule // testbench
